// >>> design/alu_timing_pkg.sv
package alu_timing_pkg;

   // -----------------------------------------------------------------
   // Operation codes
   // -----------------------------------------------------------------
   typedef enum logic [4:0] {
      add_op,
      add_with_carry_op,
      subtract_with_borrow_op,
      increment_op,
      decrement_op,
      data_pointer_inc_op,
      logical_and_op,
      logical_or_op,
      logical_xor_op,
      multiply_op,
      divide_op,
      decimal_adjust_op
   } op_type;

   // -----------------------------------------------------------------
   // Operand sources and destinations
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      mode_accumulator,
      mode_working_register,
      mode_direct,
      mode_indirect,
      mode_immediate,
      mode_direct_acc,
      mode_direct_immediate
   } addr_mode_type;

   localparam int DATA_W        = 8;
   localparam int CYCLE_CNT_W   = 4;
   localparam int BYTE_CNT_W    = 2;

   // Instruction lengths in bytes
   localparam logic [1:0] LEN_ONE   = 2'h1;
   localparam logic [1:0] LEN_TWO   = 2'h2;
   localparam logic [1:0] LEN_THREE = 2'h3;

   // Execution times in system clock cycles
   localparam logic [3:0] CYC_ONE   = 4'h1;
   localparam logic [3:0] CYC_TWO   = 4'h2;
   localparam logic [3:0] CYC_THREE = 4'h3;
   localparam logic [3:0] CYC_MUL   = 4'h4;
   localparam logic [3:0] CYC_DIV   = 4'h8;

   // Flag, accumulator and data pointer reset values
   localparam logic       CARRY_RST = 1'b0;
   localparam logic [7:0] ACC_RST   = 8'h00;
   localparam logic [15:0] DATA_POINTER_RST = 16'h0000;

endpackage

// >>> design/alu_timing_table.sv
`timescale 1ns/1ps
module alu_timing_table
   import alu_timing_pkg::*;
(
   input  op_type        op,
   input  addr_mode_type mode,
   output logic [1:0]    length,
   output logic [3:0]    cycles,
   output logic          legal
);

   always_comb begin
      length = LEN_ONE;
      cycles = CYC_ONE;
      legal  = 1'b1;
      unique case (mode)
         mode_accumulator, mode_working_register: begin
            length = LEN_ONE; // RULE1 RULE9
            cycles = CYC_ONE; // RULE1 RULE9 RULE16
         end
         mode_direct, mode_immediate, mode_direct_acc: begin
            length = LEN_TWO; // RULE2 RULE4 RULE6 RULE10 RULE12 RULE13
            cycles = CYC_TWO;
         end
         mode_indirect: begin
            length = LEN_ONE; // RULE3 RULE7 RULE11
            cycles = CYC_TWO;
         end
         mode_direct_immediate: begin
            length = LEN_THREE; // RULE14
            cycles = CYC_THREE;
         end
         default: legal = 1'b0;
      endcase
      unique case (op)
         multiply_op: begin
            length = LEN_ONE; // RULE16
            cycles = CYC_MUL;
            legal  = (mode == mode_accumulator);
         end
         divide_op: begin
            length = LEN_ONE;
            cycles = CYC_DIV;
            legal  = (mode == mode_accumulator);
         end
         decimal_adjust_op, data_pointer_inc_op: begin
            length = LEN_ONE; // RULE8
            cycles = CYC_ONE;
            legal  = (mode == mode_accumulator);
         end
         add_op, add_with_carry_op, subtract_with_borrow_op: begin
            if (mode == mode_accumulator || mode == mode_direct_acc
                || mode == mode_direct_immediate) begin
               legal = 1'b0;
            end
         end
         increment_op, decrement_op: begin
            if (mode == mode_immediate || mode == mode_direct_acc
                || mode == mode_direct_immediate) begin
               legal = 1'b0;
            end
         end
         logical_and_op, logical_or_op: begin
            if (mode == mode_accumulator) begin
               legal = 1'b0;
            end
         end
         logical_xor_op: begin
            if (mode == mode_accumulator || mode == mode_direct_immediate) begin
               legal = 1'b0;
            end
         end
         default: legal = 1'b0;
      endcase
   end

endmodule // alu_timing_table

// >>> design/arith_logic_instr_timing.sv
`timescale 1ns/1ps
// Contract
// RULE1 - Register add, add-carry, subtract-borrow: one byte, one cycle.
// RULE2 - Direct-byte add forms into accumulator: two bytes, two cycles.
// RULE3 - Indirect RAM add, add-carry, subtract-borrow: one byte, two cycles.
// RULE4 - Immediate add, add-carry, subtract-borrow: two bytes, two cycles.
// RULE5 - Subtract removes operand and borrow from accumulator, result there.
// RULE6 - Increment or decrement direct byte: two bytes, two cycles.
// RULE7 - Increment or decrement indirect RAM: one byte, two cycles.
// RULE8 - Data pointer increment: one byte, one cycle.
// RULE9 - Register AND, OR, XOR into accumulator: one byte, one cycle.
// RULE10 - Direct-byte AND, OR, XOR into accumulator: two bytes, two cycles.
// RULE11 - Indirect RAM logic into accumulator: one byte, two cycles.
// RULE12 - Immediate logic into accumulator: two bytes, two cycles.
// RULE13 - Logic from accumulator into direct byte: two bytes, two cycles.
// RULE14 - AND or OR immediate into direct byte: three bytes, three cycles.
// RULE15 - Arithmetic updates carry, aux carry, overflow; logic leaves them.
// RULE16 - Multiply, divide, decimal adjust, accumulator inc/dec follow same timing; code runs multiply in 4 cycles, divide in 8.
module arith_logic_instr_timing
   import alu_timing_pkg::*;
(
   input  wire logic          mclk,
   input  wire logic          nrst,
   input  wire logic          start,
   input  op_type             op,
   input  addr_mode_type      mode,
   input  wire logic [7:0]    operand,
   input  wire logic [7:0]    immediate,
   input  wire logic [7:0]    b_in,
   output logic               busy,
   output logic               done,
   output logic               illegal,
   output logic [1:0]         instr_length,
   output logic [3:0]         instr_cycles,
   output logic [7:0]         acc,
   output logic [7:0]         b_out,
   output logic [15:0]        data_pointer,
   output logic               carry,
   output logic               aux_carry,
   output logic               overflow,
   output logic [7:0]         mem_result,
   output logic               mem_write
);

   typedef enum logic [1:0] {st_idle, st_exec, st_done} state_type;

   // -----------------------------------------------------------------
   // Timing lookup
   // -----------------------------------------------------------------
   logic [1:0] tab_length;
   logic [3:0] tab_cycles;
   logic       tab_legal;

   alu_timing_table timing_table (
      .op     (op),
      .mode   (mode),
      .length (tab_length),
      .cycles (tab_cycles),
      .legal  (tab_legal)
   );

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   state_type      state_reg, state_next;
   logic [3:0]     count_reg, count_next;
   logic [1:0]     len_reg, len_next;
   logic [3:0]     cyc_reg, cyc_next;
   logic           ill_reg, ill_next;
   op_type         op_reg, op_next;
   addr_mode_type  mode_reg, mode_next;
   logic [7:0]     src_reg, src_next;
   logic [7:0]     imm_reg, imm_next;
   logic [7:0]     acc_reg, acc_next;
   logic [7:0]     b_reg, b_next;
   logic [15:0]    data_pointer_reg, data_pointer_next;
   logic           cy_reg, cy_next;
   logic           ac_reg, ac_next;
   logic           ov_reg, ov_next;
   logic [7:0]     mres_reg, mres_next;
   logic           mwr_reg, mwr_next;

   // -----------------------------------------------------------------
   // Datapath helpers
   // -----------------------------------------------------------------
   logic [8:0]  sum9;
   logic [4:0]  sum5;
   logic [8:0]  dif9;
   logic [4:0]  dif5;
   logic [15:0] prod;
   logic [7:0]  lhs;
   logic [7:0]  rhs;
   logic        cin;
   logic [8:0]  da_tmp;
   logic [7:0]  lres;

   always_comb begin
      // Direct destinations put the memory byte on the left
      lhs = (mode_reg == mode_direct_immediate) ? src_reg : acc_reg;
      rhs = (mode_reg == mode_direct_immediate) ? imm_reg : src_reg;
      if (mode_reg == mode_direct_acc) begin
         lhs = src_reg;
         rhs = acc_reg;
      end
      cin  = (op_reg == add_with_carry_op) ? cy_reg : 1'b0;
      sum9 = {1'b0, acc_reg} + {1'b0, src_reg} + {8'h00, cin};
      sum5 = {1'b0, acc_reg[3:0]} + {1'b0, src_reg[3:0]} + {4'h0, cin};
      // RULE5
      dif9 = {1'b0, acc_reg} - {1'b0, src_reg} - {8'h00, cy_reg};
      dif5 = {1'b0, acc_reg[3:0]} - {1'b0, src_reg[3:0]} - {4'h0, cy_reg};
      prod = {8'h00, acc_reg} * {8'h00, b_reg};
      da_tmp = {1'b0, acc_reg};
      if (ac_reg || acc_reg[3:0] > 4'h9) begin
         da_tmp = da_tmp + 9'h006;
      end
      if (cy_reg || da_tmp[8] || da_tmp[7:4] > 4'h9) begin
         da_tmp = da_tmp + 9'h060;
      end
      // One result path shared by all three logic ops
      if (op_reg == logical_and_op) begin
         lres = lhs & rhs;
      end else if (op_reg == logical_or_op) begin
         lres = lhs | rhs;
      end else begin
         lres = lhs ^ rhs;
      end
   end

   // -----------------------------------------------------------------
   // Sequencer and execution
   // -----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      len_next   = len_reg;
      cyc_next   = cyc_reg;
      ill_next   = ill_reg;
      op_next    = op_reg;
      mode_next  = mode_reg;
      src_next   = src_reg;
      imm_next   = imm_reg;
      acc_next   = acc_reg;
      b_next     = b_reg;
      data_pointer_next  = data_pointer_reg;
      cy_next    = cy_reg;
      ac_next    = ac_reg;
      ov_next    = ov_reg;
      mres_next  = mres_reg;
      mwr_next   = 1'b0;
      unique case (state_reg)
         st_idle, st_done: begin
            state_next = st_idle;
            if (start) begin
               op_next   = op;
               mode_next = mode;
               src_next  = operand;
               imm_next  = immediate;
               b_next    = b_in;
               len_next  = tab_length;
               cyc_next  = tab_cycles;
               ill_next  = ~tab_legal;
               // Done follows the taking edge by the table's whole duration
               count_next = tab_cycles - 4'h1; // RULE2 RULE3 RULE4 RULE10 RULE11 RULE12
               state_next = st_exec;
            end
         end
         st_exec: begin
            if (count_reg != 4'h0) begin
               count_next = count_reg - 4'h1;
            end else begin
               state_next = st_done;
               // Illegal forms spend the table time but change no state
               if (!ill_reg) begin
                  unique case (op_reg)
                     add_op, add_with_carry_op: begin
                        acc_next = sum9[7:0];
                        cy_next  = sum9[8]; // RULE15
                        ac_next  = sum5[4];
                        ov_next  = (acc_reg[7] == src_reg[7]) && (sum9[7] != acc_reg[7]);
                     end
                     subtract_with_borrow_op: begin
                        acc_next = dif9[7:0]; // RULE5
                        cy_next  = dif9[8]; // RULE15
                        ac_next  = dif5[4];
                        ov_next  = (acc_reg[7] != src_reg[7]) && (dif9[7] != acc_reg[7]);
                     end
                     increment_op, decrement_op: begin
                        if (mode_reg == mode_accumulator) begin
                           acc_next = (op_reg == increment_op) ? acc_reg + 8'h01
                                                               : acc_reg - 8'h01; // RULE16
                        end else begin
                           mres_next = (op_reg == increment_op) ? src_reg + 8'h01
                                                                : src_reg - 8'h01; // RULE6 RULE7
                           mwr_next  = 1'b1;
                        end
                     end
                     data_pointer_inc_op: data_pointer_next = data_pointer_reg + 16'h0001; // RULE8
                     logical_and_op, logical_or_op, logical_xor_op: begin
                        // Flags untouched by logic ops
                        if (mode_reg == mode_direct_acc || mode_reg == mode_direct_immediate) begin
                           mres_next = lres; // RULE13 RULE14
                           mwr_next  = 1'b1;
                        end else begin
                           acc_next = lres; // RULE9 RULE15
                        end
                     end
                     multiply_op: begin
                        acc_next = prod[7:0];
                        b_next   = prod[15:8];
                        cy_next  = 1'b0;
                        ov_next  = (prod[15:8] != 8'h00);
                     end
                     // Divide by zero keeps both registers; overflow flags it
                     divide_op: begin
                        cy_next = 1'b0;
                        ov_next = (b_reg == 8'h00);
                        if (b_reg != 8'h00) begin
                           acc_next = acc_reg / b_reg;
                           b_next   = acc_reg % b_reg;
                        end
                     end
                     decimal_adjust_op: begin
                        acc_next = da_tmp[7:0];
                        cy_next  = cy_reg | da_tmp[8];
                     end
                     default: ;
                  endcase
               end
            end
         end
         default: state_next = st_idle;
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= st_idle;
         count_reg <= 4'h0;
         len_reg   <= 2'h0;
         cyc_reg   <= 4'h0;
         ill_reg   <= 1'b0;
         op_reg    <= add_op;
         mode_reg  <= mode_accumulator;
         src_reg   <= 8'h00;
         imm_reg   <= 8'h00;
         acc_reg   <= ACC_RST;
         b_reg     <= 8'h00;
         data_pointer_reg  <= DATA_POINTER_RST;
         cy_reg    <= CARRY_RST;
         ac_reg    <= CARRY_RST;
         ov_reg    <= CARRY_RST;
         mres_reg  <= 8'h00;
         mwr_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         len_reg   <= len_next;
         cyc_reg   <= cyc_next;
         ill_reg   <= ill_next;
         op_reg    <= op_next;
         mode_reg  <= mode_next;
         src_reg   <= src_next;
         imm_reg   <= imm_next;
         acc_reg   <= acc_next;
         b_reg     <= b_next;
         data_pointer_reg  <= data_pointer_next;
         cy_reg    <= cy_next;
         ac_reg    <= ac_next;
         ov_reg    <= ov_next;
         mres_reg  <= mres_next;
         mwr_reg   <= mwr_next;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // Status decodes the state register, so no extra flops
   assign busy         = (state_reg == st_exec);
   assign done         = (state_reg == st_done);
   assign illegal      = ill_reg;
   assign instr_length = len_reg;
   assign instr_cycles = cyc_reg;
   assign acc          = acc_reg;
   assign b_out        = b_reg;
   assign data_pointer = data_pointer_reg;
   assign carry        = cy_reg;
   assign aux_carry    = ac_reg;
   assign overflow     = ov_reg;
   assign mem_result   = mres_reg;
   assign mem_write    = mwr_reg;

   // -----------------------------------------------------------------
   // Elaboration checks
   // -----------------------------------------------------------------
   // Longest op must fit the cycle counter and the length field
   if (int'(CYC_DIV) >= (1 << CYCLE_CNT_W)) begin : g_cycle_width_check
      $error("cycle counter too narrow for the longest op");
   end
   if (int'(LEN_THREE) >= (1 << BYTE_CNT_W)) begin : g_length_width_check
      $error("length field too narrow for the longest op");
   end

endmodule // arith_logic_instr_timing

// >>> testbench/alu_timing_checker.sv
`timescale 1ns/1ps
module alu_timing_checker
   import alu_timing_pkg::*;
(
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic        start,
   input op_type           op,
   input addr_mode_type    mode,
   input wire logic [7:0]  operand,
   input wire logic        busy,
   input wire logic        done,
   input wire logic [1:0]  instr_length,
   input wire logic [3:0]  instr_cycles,
   input wire logic [7:0]  acc,
   input wire logic [15:0] data_pointer,
   input wire logic        carry,
   input wire logic        aux_carry,
   input wire logic        overflow,
   input wire logic        mem_write
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   // -----------------------------------------------------------------
   // Launch decode
   // -----------------------------------------------------------------
   wire go    = start && !busy;
   wire arith = op inside {add_op, add_with_carry_op, subtract_with_borrow_op};
   wire logic_op = op inside {logical_and_op, logical_or_op, logical_xor_op};
   wire incdec = op inside {increment_op, decrement_op};
   wire two_two = ((arith || logic_op || incdec) && mode == mode_direct)
                  || ((arith || logic_op) && mode == mode_immediate);

   a_reg_one_cycle: assert property (go && (arith || logic_op) && mode == mode_working_register |->
      ##2 done && instr_length == LEN_ONE && instr_cycles == CYC_ONE) else $error("reg op timing");
   a_two_byte_ops: assert property (go && two_two |-> ##2 !done ##1 done
      && instr_length == LEN_TWO && instr_cycles == CYC_TWO) else $error("two byte op timing");
   a_indirect_ops: assert property (go && (arith || logic_op || incdec) && mode == mode_indirect |->
      ##2 !done ##1 done && instr_length == LEN_ONE && instr_cycles == CYC_TWO) else $error("indirect");
   a_direct_acc_write: assert property (go && logic_op && mode == mode_direct_acc |->
      ##2 !done ##1 done && mem_write && instr_length == LEN_TWO) else $error("direct,acc op");
   a_direct_imm_three: assert property (go && op inside {logical_and_op, logical_or_op}
      && mode == mode_direct_immediate |-> ##3 !done ##1 done && mem_write
      && instr_length == LEN_THREE && instr_cycles == CYC_THREE) else $error("direct,imm op");
   property p_data_pointer;
      logic [15:0] d;
      (go && op == data_pointer_inc_op && mode == mode_accumulator, d = data_pointer + 16'h0001)
      |-> ##2 done && data_pointer == d && instr_cycles == CYC_ONE;
   endproperty
   a_data_pointer_step: assert property (p_data_pointer) else $error("data pointer step");
   property p_sub;
      logic [7:0] r;
      (go && op == subtract_with_borrow_op && mode == mode_working_register,
       r = acc - operand - 8'(carry)) |-> ##2 acc == r;
   endproperty
   a_sub_borrow: assert property (p_sub) else $error("subtract result");
   property p_add;
      logic [8:0] s;
      (go && op == add_op && mode == mode_working_register, s = {1'b0, acc} + {1'b0, operand})
      |-> ##2 acc == s[7:0] && carry == s[8];
   endproperty
   a_add_carry: assert property (p_add) else $error("add carry");
   a_logic_keeps_flags: assert property (go && logic_op && mode == mode_working_register |->
      ##1 ($stable(carry) && $stable(aux_carry) && $stable(overflow))[*2]) else $error("flags moved");
   a_mul_four: assert property (go && op == multiply_op && mode == mode_accumulator |->
      ##4 !done ##1 done && instr_cycles == CYC_MUL) else $error("multiply timing");

   c_back_to_back: cover property (done && go);
   c_multiply: cover property (go && op == multiply_op);
   c_direct_imm: cover property (done && mem_write && instr_length == LEN_THREE);
endmodule // alu_timing_checker

bind arith_logic_instr_timing alu_timing_checker alu_timing_checker_inst (
   .mclk(mclk), .nrst(nrst), .start(start), .op(op), .mode(mode), .operand(operand),
   .busy(busy), .done(done), .instr_length(instr_length), .instr_cycles(instr_cycles),
   .acc(acc), .data_pointer(data_pointer), .carry(carry), .aux_carry(aux_carry),
   .overflow(overflow), .mem_write(mem_write));

// >>> testbench/test_arith_logic_instr_timing.sv
`timescale 1ns/1ps
module test_arith_logic_instr_timing;
   import alu_timing_pkg::*;

   logic          mclk = 1'b0;
   logic          nrst = 1'b0;
   logic          start = 1'b0;
   op_type        op = add_op;
   addr_mode_type mode = mode_accumulator;
   logic [7:0]    operand = 8'h00;
   logic [7:0]    immediate = 8'h00;
   logic [7:0]    b_in = 8'h00;
   logic          busy, done, illegal, carry, aux_carry, overflow, mem_write, mw;
   logic [1:0]    instr_length;
   logic [3:0]    instr_cycles;
   logic [7:0]    acc, b_out, mem_result;
   logic [15:0]   data_pointer;
   int            miscompares = 0;
   int            tests_run = 0;

   arith_logic_instr_timing arith_logic_instr_timing_inst (
      .mclk(mclk), .nrst(nrst), .start(start), .op(op), .mode(mode), .operand(operand),
      .immediate(immediate), .b_in(b_in), .busy(busy), .done(done), .illegal(illegal),
      .instr_length(instr_length), .instr_cycles(instr_cycles), .acc(acc), .b_out(b_out),
      .data_pointer(data_pointer), .carry(carry), .aux_carry(aux_carry),
      .overflow(overflow), .mem_result(mem_result), .mem_write(mem_write));

   initial begin
      forever #2 mclk = ~mclk;
   end

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Zero cycles means the timing is not judged
   task automatic run_op(input op_type o, input addr_mode_type m, input logic [7:0] opd,
                         input logic [7:0] imm, input logic [1:0] len, input logic [3:0] cyc);
      int n;
      n = 0;
      @(negedge mclk);
      op = o;
      mode = m;
      operand = opd;
      immediate = imm;
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      check("busy", 16'h0001, 16'(busy));
      while (done !== 1'b1 && n < 20) begin
         @(negedge mclk);
         n++;
      end
      mw = mem_write;
      if (cyc !== 4'h0) begin
         check("latency", 16'(cyc), 16'(n));
         check("instr_cycles", 16'(cyc), 16'(instr_cycles));
         check("instr_length", 16'(len), 16'(instr_length));
         check("illegal", 16'h0000, 16'(illegal));
      end
   endtask

   task automatic stop_test();
      $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic test_arith();
      addr_mode_type am[4] = '{mode_working_register, mode_direct, mode_indirect, mode_immediate};
      logic [1:0]    ln[4] = '{LEN_ONE, LEN_TWO, LEN_ONE, LEN_TWO};
      logic [3:0]    cy[4] = '{CYC_ONE, CYC_TWO, CYC_TWO, CYC_TWO};
      op_type        ops[7] = '{add_op, add_op, subtract_with_borrow_op, subtract_with_borrow_op,
                                add_with_carry_op, add_op, add_op};
      logic [7:0]    opd[7] = '{8'h3c, 8'hd0, 8'h05, 8'h07, 8'h00, 8'h7f, 8'h01};
      logic [7:0]    res[7] = '{8'h3c, 8'h0c, 8'h06, 8'hff, 8'h00, 8'h7f, 8'h80};
      logic [2:0]    flg[7] = '{3'h0, 3'h4, 3'h0, 3'h6, 3'h6, 3'h0, 3'h3};
      check("acc", 16'h0000, 16'(acc));
      check("data_pointer", 16'h0000, data_pointer);
      for (int i = 0; i < 3; i++) begin
         for (int j = 0; j < 4; j++) begin
            run_op(op_type'(i), am[j], 8'h00, 8'h00, ln[j], cy[j]);
         end
      end
      for (int i = 0; i < 7; i++) begin
         run_op(ops[i], mode_working_register, opd[i], 8'h00, LEN_ONE, CYC_ONE);
         check("acc", 16'(res[i]), 16'(acc));
         check("flags", 16'(flg[i]), 16'({carry, aux_carry, overflow}));
      end
      $display("test_arith finished");
   endtask

   task automatic test_logic();
      addr_mode_type am[4] = '{mode_direct, mode_indirect, mode_immediate, mode_direct_acc};
      logic [1:0]    ln[4] = '{LEN_TWO, LEN_ONE, LEN_TWO, LEN_TWO};
      logic [7:0]    res[3] = '{8'h80, 8'h8f, 8'h70};
      logic [7:0]    opd[3] = '{8'hf0, 8'h0f, 8'h8f};
      for (int i = 0; i < 3; i++) begin
         run_op(op_type'(i + 6), mode_working_register, opd[i], 8'h00, LEN_ONE, CYC_ONE);
         check("acc", 16'(res[i]), 16'(acc));
         check("flags", 16'h0003, 16'({carry, aux_carry, overflow}));
         for (int j = 0; j < 4; j++) begin
            run_op(op_type'(i + 6), am[j], 8'hff, 8'hff, ln[j], CYC_TWO);
         end
      end
      run_op(logical_or_op, mode_direct_immediate, 8'h00, 8'h00, LEN_THREE, CYC_THREE);
      run_op(logical_and_op, mode_immediate, 8'h00, 8'h00, LEN_TWO, CYC_TWO);
      run_op(logical_or_op, mode_immediate, 8'h5a, 8'h00, LEN_TWO, CYC_TWO);
      check("acc", 16'h005a, 16'(acc));
      run_op(logical_xor_op, mode_direct_acc, 8'h0f, 8'h00, LEN_TWO, CYC_TWO);
      check("mem_result", 16'h0055, 16'(mem_result));
      check("mem_write", 16'h0001, 16'(mw));
      check("acc", 16'h005a, 16'(acc));
      run_op(logical_and_op, mode_direct_immediate, 8'h3c, 8'h0f, LEN_THREE, CYC_THREE);
      check("mem_result", 16'h000c, 16'(mem_result));
      check("mem_write", 16'h0001, 16'(mw));
      $display("test_logic finished");
   endtask

   task automatic test_incdec_data_pointer();
      run_op(increment_op, mode_direct, 8'hff, 8'h00, LEN_TWO, CYC_TWO);
      check("mem_result", 16'h0000, 16'(mem_result));
      run_op(decrement_op, mode_indirect, 8'h00, 8'h00, LEN_ONE, CYC_TWO);
      check("mem_result", 16'h00ff, 16'(mem_result));
      check("mem_write", 16'h0001, 16'(mw));
      run_op(increment_op, mode_accumulator, 8'h00, 8'h00, LEN_ONE, CYC_ONE);
      check("acc", 16'h005b, 16'(acc));
      run_op(decrement_op, mode_working_register, 8'h10, 8'h00, LEN_ONE, CYC_ONE);
      check("mem_result", 16'h000f, 16'(mem_result));
      run_op(data_pointer_inc_op, mode_accumulator, 8'h00, 8'h00, LEN_ONE, CYC_ONE);
      check("data_pointer", 16'h0001, data_pointer);
      // Held start: taken in each done cycle, refused while busy
      @(negedge mclk);
      start = 1'b1;
      repeat (4) @(negedge mclk);
      start = 1'b0;
      repeat (4) @(negedge mclk);
      check("data_pointer", 16'h0003, data_pointer);
      $display("test_incdec_data_pointer finished");
   endtask

   task automatic test_muldiv();
      run_op(logical_and_op, mode_immediate, 8'h00, 8'h00, LEN_TWO, CYC_TWO);
      run_op(logical_or_op, mode_immediate, 8'h12, 8'h00, LEN_TWO, CYC_TWO);
      b_in = 8'h34;
      run_op(multiply_op, mode_accumulator, 8'h00, 8'h00, LEN_ONE, CYC_MUL);
      check("product", 16'h03a8, {b_out, acc});
      b_in = 8'h10;
      run_op(divide_op, mode_accumulator, 8'h00, 8'h00, LEN_ONE, CYC_DIV);
      check("quotient", 16'h080a, {b_out, acc});
      run_op(decimal_adjust_op, mode_accumulator, 8'h00, 8'h00, LEN_ONE, CYC_ONE);
      run_op(multiply_op, mode_direct, 8'h55, 8'h00, LEN_ONE, 4'h0);
      check("illegal", 16'h0001, 16'(illegal));
      check("acc", 16'h0010, 16'(acc));
      $display("test_muldiv finished");
   endtask

   initial begin
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      nrst = 1'b1;
      test_arith();
      test_logic();
      test_incdec_data_pointer();
      test_muldiv();
      stop_test();
   end

   // Whole run needs about 210 cycles
   initial begin
      #40000;
      miscompares++;
      stop_test();
   end
endmodule // test_arith_logic_instr_timing
